// [rtl/uart_multidrop_rx.sv]
// Multidrop receive control, receive queue, watchdog and time-out counter.
`timescale 1ns/1ps
`default_nettype none

module uart_multidrop_rx #(
  parameter int QDEPTH = 256
) (
  // Clock, reset and clock enable.
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  // Register port.
  input wire logic [uart_wake_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [uart_wake_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [uart_wake_pkg::DATA_W-1:0] reg_rdata,
  // Timing ticks.
  input wire logic bit_tick,
  input wire logic ct_tick,
  // Characters from the receive shifter.
  input wire logic rx_char_stb,
  input wire logic [7:0] rx_char_data,
  input wire logic rx_char_ninth,
  input wire logic rx_char_perr,
  input wire logic rx_char_ferr,
  input wire logic rx_char_brk,
  // Control toward the shifters.
  output logic rx_run,
  output logic rx_drop,
  output logic tx_ninth,
  output logic tx_ninth_en,
  // Event outputs.
  output logic wd_irq,
  output logic ct_irq
);
  import uart_wake_pkg::*;

  localparam int AW = $clog2(QDEPTH);

  typedef struct packed {
    logic [7:0] mr0;
    logic [7:0] mr1;
    logic [7:0] mr3;
    logic [7:0] rce;
    logic [7:0] pre_hi;
    logic [7:0] pre_lo;
    logic [7:0] adr_char;
    logic [7:0] interrupt_enable_mask;
    logic rx_en;
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic ovr;
    logic [6:0] wd_cnt;
    logic wd_flag;
    logic [15:0] ct_val;
    logic ct_run;
    logic tmo;
    ct_phase_t ct_ph;
    logic ct_rdy;
    logic [7:0] rdata;
    logic rx_run;
    logic rx_drop;
    logic tx_ninth;
    logic tx_ninth_en;
    logic wd_irq;
    logic ct_irq;
  } state_t;

  state_t q;
  state_t n;

  logic [10:0] queue_mem [QDEPTH];
  logic [10:0] head;
  logic [AW:0] fill;
  logic empty;
  logic full;
  logic wake;
  logic own;
  logic store;
  logic push;
  logic [10:0] push_word;
  logic [15:0] preset;

  always_comb begin
    n = q;
    n.rx_drop = 1'b0;
    n.rdata = 8'h00;
    push = 1'b0;
    store = 1'b0;
    own = 1'b0;
    push_word = {rx_char_brk, rx_char_ferr, rx_char_perr, rx_char_data};
    preset = {q.pre_hi, q.pre_lo};
    wake = (q.mr1[MR1_PAR_HI:MR1_PAR_LO] == PAR_WAKE);
    fill = q.wr_ptr - q.rd_ptr;
    empty = (fill == '0);
    full = (fill == (AW + 1)'(QDEPTH));
    head = queue_mem[q.rd_ptr[AW-1:0]];

    // Register reads.
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_MODE_ZERO: n.rdata = q.mr0;
        OFS_MODE_ONE: n.rdata = q.mr1;
        OFS_MODE_THREE: n.rdata = q.mr3;
        OFS_RECOG_EN: n.rdata = q.rce;
        OFS_PRESET_HI: n.rdata = q.pre_hi;
        OFS_PRESET_LO: n.rdata = q.pre_lo;
        OFS_ADDR_CHAR: n.rdata = q.adr_char;
        OFS_IRQ_MASK: n.rdata = q.interrupt_enable_mask;
        OFS_CMD_STATUS: begin
          n.rdata = {empty ? 3'b000 : head[10:8], q.ovr, 2'b00, full, !empty};
        end
        OFS_QUEUE: begin
          n.wd_cnt = 7'h00;
          n.wd_flag = 1'b0;
          if (!empty) begin
            n.rdata = head[7:0];
            n.rd_ptr = q.rd_ptr + (AW + 1)'(1);
          end
        end
        OFS_IRQ_FLAGS: begin
          n.rdata = 8'h00;
          n.rdata[FLAG_WD] = q.wd_flag;
          n.rdata[FLAG_CT] = q.ct_rdy;
        end
        OFS_CT_HI: n.rdata = q.ct_val[15:8];
        OFS_CT_LO: n.rdata = q.ct_val[7:0];
        default: n.rdata = 8'h00;
      endcase
    end

    // Register writes and commands.
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_MODE_ZERO: n.mr0 = reg_wdata;
        OFS_MODE_ONE: n.mr1 = reg_wdata;
        OFS_MODE_THREE: n.mr3 = reg_wdata;
        OFS_RECOG_EN: n.rce = reg_wdata;
        OFS_PRESET_HI: n.pre_hi = reg_wdata;
        OFS_PRESET_LO: n.pre_lo = reg_wdata;
        OFS_ADDR_CHAR: n.adr_char = reg_wdata;
        OFS_IRQ_MASK: n.interrupt_enable_mask = reg_wdata;
        OFS_CMD_STATUS: begin
          if (reg_wdata[1:0] == CMD_RX_ON) begin
            n.rx_en = 1'b1;
          end else if (reg_wdata[1:0] == CMD_RX_OFF) begin
            n.rx_en = 1'b0;
            n.rx_drop = 1'b1;
          end
          unique case (reg_wdata[7:4])
            CMD_RX_RESET: begin
              n.rx_en = 1'b0;
              n.rx_drop = 1'b1;
              n.rd_ptr = q.wr_ptr;
            end
            CMD_ERR_RESET: n.ovr = 1'b0;
            CMD_CT_START: begin
              if (!q.tmo) begin
                n.ct_val = preset;
                n.ct_run = 1'b1;
              end
            end
            CMD_CT_STOP: begin
              if (!q.tmo) begin
                n.ct_run = 1'b0;
                n.ct_rdy = 1'b0;
              end
            end
            CMD_TMO_ON: begin
              n.tmo = 1'b1;
              n.ct_rdy = 1'b0;
              n.ct_run = 1'b0;
              n.ct_ph = CT_NORMAL;
            end
            CMD_TMO_OFF: begin
              n.tmo = 1'b0;
              n.ct_rdy = 1'b0;
              n.ct_ph = CT_NORMAL;
            end
            default: begin
            end
          endcase
        end
        default: begin
        end
      endcase
    end

    // Character recognition and queueing.
    if (rx_char_stb && (q.rx_en || wake)) begin
      if (!wake) begin
        store = 1'b1;
      end else begin
        push_word[8] = rx_char_ninth;
        if (!rx_char_ninth) begin
          store = q.rx_en;
        end else if (q.mr3[1:0] == SUB_HOST) begin
          store = 1'b1;
        end else begin
          own = (rx_char_data == q.adr_char);
          store = q.mr0[MR0_LOAD_ADR];
          if (own && q.mr3[0]) begin
            n.rx_en = 1'b1;
          end
          if (!own && q.mr3[1]) begin
            n.rx_en = 1'b0;
          end
        end
      end
      if (store) begin
        if (full) begin
          n.ovr = 1'b1;
        end else begin
          push = 1'b1;
          n.wr_ptr = q.wr_ptr + (AW + 1)'(1);
        end
      end
    end

    // Receive watchdog.
    if (bit_tick && !n.wd_flag) begin
      if (n.wd_cnt == WD_BIT_TIMES - 7'h01) begin
        n.wd_flag = 1'b1;
      end else begin
        n.wd_cnt = n.wd_cnt + 7'h01;
      end
    end

    // Counter/timer.
    if (ct_tick) begin
      unique case (q.ct_ph)
        CT_STOP_WAIT: begin
          n.ct_run = 1'b0;
          n.ct_val = preset;
          n.ct_ph = CT_RESTART;
        end
        CT_RESTART: begin
          n.ct_run = 1'b1;
          n.ct_ph = CT_NORMAL;
        end
        default: begin
          if (q.ct_run) begin
            if (q.ct_val == 16'h0000) begin
              n.ct_rdy = 1'b1;
              if (q.tmo) begin
                n.ct_run = 1'b0;
              end else begin
                n.ct_val = preset;
              end
            end else begin
              n.ct_val = q.ct_val - 16'h0001;
            end
          end
          n.ct_ph = CT_NORMAL;
        end
      endcase
    end
    if (push && n.tmo) begin
      n.ct_ph = CT_STOP_WAIT;
    end

    // Registered outputs.
    n.rx_run = n.rx_en;
    n.tx_ninth_en = (n.mr1[MR1_PAR_HI:MR1_PAR_LO] == PAR_WAKE);
    n.tx_ninth = n.tx_ninth_en && n.mr1[MR1_AD_BIT];
    n.wd_irq = n.wd_flag && n.rce[RCE_WD_EN];
    n.ct_irq = n.ct_rdy && n.interrupt_enable_mask[MASK_CT];
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      q <= '0;
      q.mr0 <= REG_RESET;
      q.mr1 <= REG_RESET;
      q.mr3 <= REG_RESET;
      q.rce <= REG_RESET;
      q.pre_hi <= REG_RESET;
      q.pre_lo <= REG_RESET;
      q.adr_char <= REG_RESET;
      q.interrupt_enable_mask <= REG_RESET;
      q.rdata <= REG_RESET;
      q.ct_ph <= CT_NORMAL;
    end else if (clk_en) begin
      q <= n;
    end
  end

  // Stored characters are never cleared; only the pointers move.
  always_ff @(posedge core_clk) begin
    if (clk_en && !srst && push) begin
      queue_mem[q.wr_ptr[AW-1:0]] <= push_word;
    end
  end

  assign reg_rdata = q.rdata;
  assign rx_run = q.rx_run;
  assign rx_drop = q.rx_drop;
  assign tx_ninth = q.tx_ninth;
  assign tx_ninth_en = q.tx_ninth_en;
  assign wd_irq = q.wd_irq;
  assign ct_irq = q.ct_irq;

endmodule

`default_nettype wire

// [rtl/uart_wake_pkg.sv]
// Constants, offsets and types for the multidrop receive control block.
package uart_wake_pkg;

  // Register bus widths.
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // Register offsets.
  localparam logic [3:0] OFS_MODE_ZERO = 4'h0;
  localparam logic [3:0] OFS_MODE_ONE = 4'h1;
  localparam logic [3:0] OFS_MODE_THREE = 4'h2;
  localparam logic [3:0] OFS_RECOG_EN = 4'h3;
  localparam logic [3:0] OFS_PRESET_HI = 4'h4;
  localparam logic [3:0] OFS_PRESET_LO = 4'h5;
  localparam logic [3:0] OFS_ADDR_CHAR = 4'h6;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h7;
  localparam logic [3:0] OFS_CMD_STATUS = 4'h8;
  localparam logic [3:0] OFS_QUEUE = 4'h9;
  localparam logic [3:0] OFS_IRQ_FLAGS = 4'ha;
  localparam logic [3:0] OFS_CT_HI = 4'hb;
  localparam logic [3:0] OFS_CT_LO = 4'hc;

  // Reset value of every software register.
  localparam logic [7:0] REG_RESET = 8'h00;

  // Field positions.
  localparam int MR1_PAR_HI = 4;
  localparam int MR1_PAR_LO = 3;
  localparam int MR1_AD_BIT = 2;
  localparam int MR0_LOAD_ADR = 6;
  localparam int RCE_WD_EN = 0;
  localparam int FLAG_WD = 6;
  localparam int FLAG_CT = 3;
  localparam int MASK_CT = 3;

  // Field values.
  localparam logic [1:0] PAR_WAKE = 2'b11;
  localparam logic [1:0] SUB_HOST = 2'b00;
  localparam logic [1:0] CMD_RX_ON = 2'b01;
  localparam logic [1:0] CMD_RX_OFF = 2'b10;
  localparam logic [3:0] CMD_RX_RESET = 4'h2;
  localparam logic [3:0] CMD_ERR_RESET = 4'h4;
  localparam logic [3:0] CMD_CT_START = 4'h8;
  localparam logic [3:0] CMD_CT_STOP = 4'h9;
  localparam logic [3:0] CMD_TMO_ON = 4'ha;
  localparam logic [3:0] CMD_TMO_OFF = 4'hc;

  // Watchdog length in bit times.
  localparam logic [6:0] WD_BIT_TIMES = 7'h40;

  // Counter reload sequence in time-out mode.
  typedef enum logic [1:0] {
    CT_NORMAL = 2'b00,
    CT_STOP_WAIT = 2'b01,
    CT_RESTART = 2'b11
  } ct_phase_t;

endpackage

// [dv/uart_multidrop_rx_props.sv]
// Port assertions for the multidrop receive control block.
`timescale 1ns/1ps
`default_nettype none
module uart_multidrop_rx_props #(
  parameter int QDEPTH = 256
) (
  // Clock, reset and enable.
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  // Register port.
  input wire logic [uart_wake_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [uart_wake_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [uart_wake_pkg::DATA_W-1:0] reg_rdata,
  // Ticks and characters.
  input wire logic bit_tick,
  input wire logic ct_tick,
  input wire logic rx_char_stb,
  input wire logic [7:0] rx_char_data,
  input wire logic rx_char_ninth,
  input wire logic rx_char_perr,
  input wire logic rx_char_ferr,
  input wire logic rx_char_brk,
  // Block outputs.
  input wire logic rx_run,
  input wire logic rx_drop,
  input wire logic tx_ninth,
  input wire logic tx_ninth_en,
  input wire logic wd_irq,
  input wire logic ct_irq
);
  import uart_wake_pkg::*;
  logic [7:0] own_r;
  logic [1:0] sub_r;
  logic wake_r, wden_r, msk_r;
  wire logic wr_ok = reg_wr && clk_en;
  wire logic cmd = wr_ok && reg_addr == OFS_CMD_STATUS;
  wire logic chr = rx_char_stb && clk_en && !wr_ok && wake_r && rx_char_ninth;
  // Mirrors mode registers one and three, the address and the enable registers.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      own_r <= 8'h00;
      sub_r <= 2'b00;
      wake_r <= 1'b0;
      wden_r <= 1'b0;
      msk_r <= 1'b0;
    end else if (wr_ok) begin
      if (reg_addr == OFS_ADDR_CHAR) own_r <= reg_wdata;
      if (reg_addr == OFS_MODE_THREE) sub_r <= reg_wdata[1:0];
      if (reg_addr == OFS_MODE_ONE) wake_r <= reg_wdata[4:3] == PAR_WAKE;
      if (reg_addr == OFS_RECOG_EN) wden_r <= reg_wdata[RCE_WD_EN];
      if (reg_addr == OFS_IRQ_MASK) msk_r <= reg_wdata[MASK_CT];
    end
  end
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (srst);
  wake_enable_a: assert property (
    wr_ok && reg_addr == OFS_MODE_ONE |=> tx_ninth_en == wake_r)
    else $error("tx_ninth_en wrong");
  ad_bit_a: assert property (
    wr_ok && reg_addr == OFS_MODE_ONE && reg_wdata[MR1_AD_BIT] &&
    reg_wdata[4:3] == PAR_WAKE |=> tx_ninth) else $error("tx_ninth wrong");
  rx_off_a: assert property (
    cmd && reg_wdata[1:0] == CMD_RX_OFF |=> rx_drop && !rx_run)
    else $error("disable not seen");
  rx_on_a: assert property (
    cmd && reg_wdata == 8'h01 |=> rx_run) else $error("enable not seen");
  rx_reset_a: assert property (
    cmd && reg_wdata[7:4] == CMD_RX_RESET |=> rx_drop && !rx_run)
    else $error("reset not seen");
  auto_wake_a: assert property (
    chr && sub_r[0] && rx_char_data == own_r |=> rx_run)
    else $error("auto wake missed");
  auto_doze_a: assert property (
    chr && sub_r[1] && rx_char_data != own_r |=> !rx_run)
    else $error("auto doze missed");
  tmo_clear_a: assert property (
    cmd && (reg_wdata[7:4] == CMD_TMO_ON || reg_wdata[7:4] == CMD_TMO_OFF)
    |=> ##1 !ct_irq) else $error("counter ready kept");
  wd_gate_a: assert property ($rose(wd_irq) |-> wden_r)
    else $error("watchdog event not enabled");
  ct_gate_a: assert property ($rose(ct_irq) |-> msk_r)
    else $error("counter event not masked in");
endmodule
bind uart_multidrop_rx uart_multidrop_rx_props #(.QDEPTH(QDEPTH)) props (
  .core_clk(core_clk), .srst(srst), .clk_en(clk_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .bit_tick(bit_tick), .ct_tick(ct_tick),
  .rx_char_stb(rx_char_stb), .rx_char_data(rx_char_data),
  .rx_char_ninth(rx_char_ninth), .rx_char_perr(rx_char_perr),
  .rx_char_ferr(rx_char_ferr), .rx_char_brk(rx_char_brk), .rx_run(rx_run),
  .rx_drop(rx_drop), .tx_ninth(tx_ninth), .tx_ninth_en(tx_ninth_en),
  .wd_irq(wd_irq), .ct_irq(ct_irq));
`default_nettype wire

// [dv/party_station.sv]
// Behavioural station on the shared party line delivering characters.
`timescale 1ns/1ps
`default_nettype none
module party_station (
  // Clock.
  input wire logic core_clk,
  // Character toward the receive control.
  output var logic stb = 1'b0,
  output var logic [7:0] data = 8'h00,
  output var logic ninth = 1'b0,
  output var logic perr = 1'b0,
  output var logic ferr = 1'b0,
  output var logic brk = 1'b0
);
  // Sends one whole character; a set ninth bit marks an address.
  task automatic send(input logic [7:0] d, input logic n);
    @(posedge core_clk);
    stb <= 1'b1;
    data <= d;
    ninth <= n;
    @(posedge core_clk);
    stb <= 1'b0;
    data <= ~d;
    ninth <= ~n;
  endtask
endmodule
`default_nettype wire

// [dv/tb_top.sv]
// Self-checking bench for the multidrop receive control block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import uart_wake_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic clk_en = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic bit_tick = 1'b0;
  logic ct_tick = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata, cdat, d, own;
  logic stb, ninth, perr, ferr, brk, rx_run, rx_drop, txn, txe, wdi, cti;
  int num_errors = 0;
  int checked = 0;
  always #5 core_clk = ~core_clk;
  party_station st (.core_clk(core_clk), .stb(stb), .data(cdat),
    .ninth(ninth), .perr(perr), .ferr(ferr), .brk(brk));
  uart_multidrop_rx #(.QDEPTH(8)) dut (.core_clk(core_clk), .srst(srst),
    .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bit_tick(bit_tick), .ct_tick(ct_tick), .rx_char_stb(stb),
    .rx_char_data(cdat), .rx_char_ninth(ninth), .rx_char_perr(perr),
    .rx_char_ferr(ferr), .rx_char_brk(brk), .rx_run(rx_run),
    .rx_drop(rx_drop), .tx_ninth(txn), .tx_ninth_en(txe), .wd_irq(wdi),
    .ct_irq(cti));
  function automatic logic [7:0] stat(input logic ad, input logic rdy);
    return {2'b00, ad, 4'h0, rdy};
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input string n, input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(n, e, reg_rdata);
  endtask
  task automatic settle;
    @(posedge core_clk);
    #1;
  endtask
  task automatic ticks(input logic w, input int n);
    repeat (n) begin
      @(posedge core_clk);
      bit_tick <= w;
      ct_tick <= !w;
      @(posedge core_clk);
      bit_tick <= 1'b0;
      ct_tick <= 1'b0;
    end
    settle;
  endtask
  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h7883));
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    for (int a = 0; a < 8; a++) rdc("register", a[3:0], REG_RESET);
    wr(4'hf, 8'h5a);
    rdc("unmapped", 4'hf, 8'h00);
    own = 8'($urandom);
    wr(OFS_ADDR_CHAR, own);
    wr(OFS_MODE_ONE, 8'h1c);
    settle;
    chk("tx_ninth_en", 8'h01, {7'h00, txe});
    chk("tx_ninth", 8'h01, {7'h00, txn});
    st.send(8'h3c, 1'b0);
    rdc("status", OFS_CMD_STATUS, stat(1'b0, 1'b0));
    d = 8'($urandom);
    st.send(d, 1'b1);
    wr(OFS_CMD_STATUS, 8'h02);
    #1;
    chk("rx_drop", 8'h01, {7'h00, rx_drop});
    rdc("status", OFS_CMD_STATUS, stat(1'b1, 1'b1));
    rdc("queue", OFS_QUEUE, d);
    wr(OFS_CMD_STATUS, 8'h01);
    repeat (3) begin
      d = 8'($urandom);
      st.send(d, 1'b0);
      rdc("queue", OFS_QUEUE, d);
    end
    st.send(d, 1'b1);
    wr(OFS_CMD_STATUS, 8'h20);
    rdc("status", OFS_CMD_STATUS, stat(1'b0, 1'b0));
    chk("rx_run", 8'h00, {7'h00, rx_run});
    wr(OFS_MODE_ZERO, 8'h40);
    wr(OFS_MODE_THREE, 8'h03);
    st.send(own, 1'b1);
    settle;
    chk("rx_run", 8'h01, {7'h00, rx_run});
    rdc("queue", OFS_QUEUE, own);
    st.send(~own, 1'b1);
    settle;
    chk("rx_run", 8'h00, {7'h00, rx_run});
    rdc("queue", OFS_QUEUE, ~own);
    wr(OFS_MODE_ZERO, 8'h00);
    st.send(own, 1'b1);
    rdc("status", OFS_CMD_STATUS, stat(1'b0, 1'b0));
    wr(OFS_PRESET_HI, 8'h00);
    wr(OFS_PRESET_LO, 8'h03);
    wr(OFS_IRQ_MASK, 8'h08);
    wr(OFS_CMD_STATUS, 8'ha0);
    wr(OFS_CMD_STATUS, 8'h80);
    ticks(1'b0, 10);
    chk("ct_irq", 8'h00, {7'h00, cti});
    d = 8'($urandom);
    st.send(d, 1'b0);
    ticks(1'b0, 5);
    chk("ct_irq", 8'h00, {7'h00, cti});
    ticks(1'b0, 1);
    chk("ct_irq", 8'h01, {7'h00, cti});
    rdc("flags", OFS_IRQ_FLAGS, 8'h08);
    wr(OFS_CMD_STATUS, 8'hc0);
    rdc("flags", OFS_IRQ_FLAGS, 8'h00);
    wr(OFS_RECOG_EN, 8'h01);
    rdc("queue", OFS_QUEUE, d);
    ticks(1'b1, 63);
    chk("wd_irq", 8'h00, {7'h00, wdi});
    ticks(1'b1, 1);
    chk("wd_irq", 8'h01, {7'h00, wdi});
    tally_and_finish;
  end
endmodule
`default_nettype wire
